// file: tb/cct_checker_assertions.sv
/*
 checker for the timer block: sync, rollover, carry, trigger, disable, aux.
 assumes binding to the top module with the same SRC_COUNT.
*/
`timescale 1ns/1ps
`default_nettype none
module cct_checker #(
  parameter SRC_COUNT = 32
) (
  input wire logic                 clk, rstn, tick, module_enable, capture_select,
  input wire logic [3:0]           function_code,
  input wire logic                 wide_timer_select, trigger_enable, trigger_clear,
  input wire logic [4:0]           source_select,
  input wire logic [SRC_COUNT-1:0] source_in,
  input wire logic [1:0]           auxiliary_select,
  input wire logic                 counter_write,
  input wire logic [15:0]          period_low, period_high, counter_low, counter_high,
  input wire logic                 trigger_status, compare_out, sync_out, aux_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic tmr = module_enable && !capture_select && function_code == 4'h0 && !counter_write;
  wire logic src = source_in[source_select];
  a_sync_single: assert property (sync_out && !tick |=> !sync_out)
    else $error("sync pulse too long");
  a_roll_zero: assert property (tmr && tick && !wide_timer_select && !trigger_enable
    && source_select == 5'h00 && counter_low == period_low |=> sync_out ##1 counter_low == 16'h0000)
    else $error("no rollover on period match");
  a_wide_carry: assert property (tmr && tick && wide_timer_select && !trigger_enable
    && source_select == 5'h00 && counter_low == 16'hFFFF && {counter_high, counter_low} !=
    {period_high, period_low} |-> ##2 counter_high == $past(counter_high, 2) + 16'h0001)
    else $error("high half missed the carry");
  a_sync_clear: assert property (tmr && !trigger_enable && source_select != 5'h00 && src
    |-> ##[1:2] counter_low == 16'h0000) else $error("sync did not clear timer");
  a_trig_hold: assert property (tmr && trigger_enable && !trigger_status && !src
    |-> ##2 counter_low == 16'h0000) else $error("timer ran before trigger");
  a_trig_set: assert property (tmr && trigger_enable && source_select != 5'h00 && src
    |=> trigger_status) else $error("trigger not taken");
  a_trig_clear: assert property (tmr && trigger_enable && trigger_status && trigger_clear && !src
    |=> !trigger_status ##2 counter_low == 16'h0000) else $error("trigger clear ignored");
  a_off_quiet: assert property (!module_enable [*2] |=> counter_low == 16'h0000
    && !compare_out && !aux_out) else $error("disabled block not quiet");
  a_aux_off: assert property (auxiliary_select == 2'h0 |=> !aux_out)
    else $error("aux out while disabled");
endmodule // cct_checker
bind capture_compare_timer cct_checker #(.SRC_COUNT(SRC_COUNT)) u_chk (.clk(clk), .rstn(rstn),
  .tick(tick), .module_enable(module_enable), .capture_select(capture_select),
  .function_code(function_code), .wide_timer_select(wide_timer_select),
  .trigger_enable(trigger_enable), .trigger_clear(trigger_clear),
  .source_select(source_select), .source_in(source_in), .auxiliary_select(auxiliary_select),
  .counter_write(counter_write), .period_low(period_low), .period_high(period_high),
  .counter_low(counter_low), .counter_high(counter_high), .trigger_status(trigger_status),
  .compare_out(compare_out), .sync_out(sync_out), .aux_out(aux_out));
`default_nettype wire

// file: tb/source_model.sv
/*
 far-side model: other on-chip timers pulsing their sync lines.
 assumes it shares clk and rstn with the timer block.
*/
`timescale 1ns/1ps
`default_nettype none
module source_model #(
  parameter SRC_COUNT = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 fire,
  input  wire logic [4:0]           index,
  output var  logic [SRC_COUNT-1:0] source_in
);
  // one-cycle pulse, so a sync clears the timer once and not for a span
  always @(posedge clk or negedge rstn) begin
    if (!rstn) source_in <= '0;
    else if (fire && index != 5'h00) source_in <= SRC_COUNT'(1'b1) << index;
    else source_in <= '0;
  end
  // the bench never asks for index 11111
endmodule // source_model
`default_nettype wire

// file: tb/tb.sv
/*
 bench for the timer block: timer, sync, trigger, 32-bit, compare, capture.
 assumes the source model stands in for the other timers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, tick, en, csel, wide, trg, tclr, inh, pin, cwr, pop, fire;
  logic [3:0] fc;
  logic [4:0] ssel, idx;
  logic [1:0] aux;
  logic [15:0] pl, ph, cal, wl, wh;
  wire logic [31:0] src, fd;
  wire logic [15:0] cl, ch;
  wire logic fe, ts, co, so, ao;
  int n_mismatch, compares, n_sync, n_aux, n_cmp;
  wire logic n_cmp_w;
  source_model #(.SRC_COUNT(32)) i_src (.clk(clk), .rstn(rstn), .fire(fire), .index(idx),
    .source_in(src));
  capture_compare_timer #(.SRC_COUNT(32)) i_dut (.clk(clk), .rstn(rstn), .tick(tick),
    .module_enable(en), .capture_select(csel), .function_code(fc), .wide_timer_select(wide),
    .trigger_enable(trg), .trigger_clear(tclr), .source_select(ssel), .source_in(src),
    .auxiliary_select(aux), .capture_inhibit(inh), .capture_pin(pin), .period_low(pl),
    .period_high(ph), .compare_a_low(cal), .compare_a_high(16'h0000), .compare_b(16'h0000),
    .counter_write(cwr), .counter_low_wdata(wl), .counter_high_wdata(wh), .fifo_pop(pop),
    .counter_low(cl), .counter_high(ch), .fifo_data(fd), .fifo_empty(fe), .fifo_overflow(),
    .trigger_status(ts), .compare_out(co), .sync_out(so), .primary_irq(), .secondary_irq(),
    .compare_irq(n_cmp_w), .capture_irq(), .aux_out(ao));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    n_sync += (so === 1'b1);
    n_aux += (ao === 1'b1);
    n_cmp += (n_cmp_w === 1'b1);
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // two edges a tick: rollover pulses can never merge
  task ticks(input int n);
    repeat (n) begin
      @(posedge clk); tick <= 1'b1;
      @(posedge clk); tick <= 1'b0;
    end
    cyc(2);
  endtask
  task kick(input int w);
    @(posedge clk);
    case (w)
      0: fire <= 1'b1;
      1: cwr <= 1'b1;
      2: tclr <= 1'b1;
      default: pop <= 1'b1;
    endcase
    @(posedge clk); {fire, cwr, tclr, pop} <= 4'h0;
    cyc(3);
  endtask
  task s_timer;
    @(posedge clk); en <= 1'b1; pl <= 16'h0003; ph <= 16'h0002; aux <= 2'h1;
    ticks(2);
    chk("low count", cl, 32'h2);
    chk("high count", ch, 32'h2);
    ticks(2);
    chk("low roll", cl, 32'h0);
    chk("high roll", ch, 32'h1);
    chk("sync count", n_sync, 32'h1);
    chk("aux roll", n_aux, 32'h1);
  endtask
  task s_sync;
    @(posedge clk); aux <= 2'h0; ssel <= 5'h05; idx <= 5'h05;
    ticks(1);
    kick(0);
    chk("sync clear", cl, 32'h0);
    ticks(1);
    @(posedge clk); idx <= 5'h06;
    kick(0);
    chk("other source", cl, 32'h1);
  endtask
  task s_trigger;
    @(posedge clk); trg <= 1'b1; idx <= 5'h05;
    ticks(2);
    chk("held", cl, 32'h0);
    kick(0);
    chk("status", ts, 32'h1);
    ticks(2);
    chk("run", cl, 32'h2);
    kick(2);
    chk("cleared", {ts, cl}, 32'h0);
    ticks(1);
    chk("held again", cl, 32'h0);
  endtask
  task s_carry;
    // wide select goes first, then the load
    @(posedge clk); trg <= 1'b0; ssel <= 5'h00; wide <= 1'b1;
    pl <= 16'hFFFF; ph <= 16'hFFFF; wl <= 16'hFFFF; wh <= 16'h0002;
    kick(1);
    ticks(1);
    chk("carry", {ch, cl}, 32'h00030000);
  endtask
  task s_compare;
    int b;
    int a;
    @(posedge clk); wide <= 1'b0; pl <= 16'h0005; cal <= 16'h0002; wl <= 16'h0000;
    aux <= 2'h2;
    kick(1);
    b = n_cmp;
    a = n_aux;
    for (int k = 1; k < 4; k++) begin
      @(posedge clk); fc <= k[3:0];
      ticks(6);
      chk("compare out", co, {31'h0, k != 2});
    end
    chk("compare irq", 32'(n_cmp > b), 32'h1);
    chk("aux event", 32'(n_aux > a), 32'h1);
  endtask
  task s_capture;
    @(posedge clk); aux <= 2'h0; fc <= 4'h1; csel <= 1'b1;
    cyc(4);
    chk("empty", fe, 32'h1);
    @(posedge clk); pin <= 1'b1;
    cyc(8);
    chk("captured", fe, 32'h0);
    chk("capture high half", {16'h0000, fd[31:16]}, 32'h0);
    kick(3);
    chk("popped", fe, 32'h1);
    @(posedge clk); pin <= 1'b0; fc <= 4'h2;
    cyc(8);
    chk("fall capture", fe, 32'h0);
  endtask
  task s_off;
    @(posedge clk); en <= 1'b0; csel <= 1'b0; fc <= 4'h0;
    cyc(3);
    chk("off", {co, cl}, 32'h0);
  endtask
  task conclude;
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    {tick, en, csel, wide, trg, tclr, inh, pin, cwr, pop, fire, fc, ssel, idx, aux} = '0;
    {pl, ph, cal, wl, wh} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    s_timer;
    s_sync;
    s_trigger;
    s_carry;
    s_compare;
    s_capture;
    s_off;
    conclude;
  end
  initial begin
    #100000;
    n_mismatch++;
    conclude;
  end
endmodule // tb
`default_nettype wire

// file: verilog/capture_compare_timer.v
/*
 capture/compare/timer block: dual 16 or 32-bit timer with sync/trigger,
 compare output modes, edge capture into a 4-deep fifo, auxiliary output.
 assumes control fields come in as static ports, sources are same-clock
 logic, capture pin is asynchronous, tick is a one-cycle time-base enable.
*/
// Function
// (R1) capture_select 0 and function code 0000 gives plain timer, outputs off
// (R2) wide_timer_select picks two 16-bit timers or one 32-bit timer
// (R3) primary timer uses low counter/period; only it syncs in and out
// (R4) secondary uses high counter/period; interrupt only, no sync or trigger; the code also clears it while the trigger holds the timer
// (R5) in 32-bit mode high counter increments on low counter overflow
// (R6) software sets wide select before writing counter or period
// (R7) five-bit source select chooses the sync/trigger input
// (R8) trigger disabled: selected source clears timer, counting resumes at zero
// (R9) software avoids source value 11111 in sync operation
// (R10) trigger enabled: timer held in reset until source asserts
// (R11) trigger status keeps timer running; trigger clear resets and holds it
// (R12) codes 0001/0010/0011 drive output high, low, toggle on match
// (R13) 0100 dual-edge compare, 0101 buffered dual-edge pwm
// (R14) 0110 buffered center-aligned pulse
// (R15) 0111 variable frequency pulse, 16 or 32-bit
// (R16) compare against one or two registers, interrupt on match
// (R17) capture uses own up-counting timer, value written to fifo on event
// (R18) capture timer readable through counter outputs after sync delay
// (R19) capture codes: edge, rise, fall, both, 4th rise, 16th rise
// (R20) auxiliary select 00 disables auxiliary output always
// (R21) timer aux: 01 rollover, 10 special event, 11 nothing
// (R22) compare aux: roll, event, signal; capture aux: roll, inhibit, event; the code's capture roll stays low, the general timer being held at zero
// (R23) module enable runs the selected mode, disabled when 0
// (R24) source 00000: roll over on period match or all ones
// (R25) primary period match returns to zero next tick, drives sync out
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_timer_consts.vh"
module capture_compare_timer #(
  parameter SRC_COUNT = 32
) (
  input  wire                 clk,
  input  wire                 rstn,
  input  wire                 tick,
  input  wire                 module_enable,
  input  wire                 capture_select,
  input  wire [3:0]           function_code,
  input  wire                 wide_timer_select,
  input  wire                 trigger_enable,
  input  wire                 trigger_clear,
  input  wire [4:0]           source_select,
  input  wire [SRC_COUNT-1:0] source_in,
  input  wire [1:0]           auxiliary_select,
  input  wire                 capture_inhibit,
  input  wire                 capture_pin,
  input  wire [15:0]          period_low,
  input  wire [15:0]          period_high,
  input  wire [15:0]          compare_a_low,
  input  wire [15:0]          compare_a_high,
  input  wire [15:0]          compare_b,
  input  wire                 counter_write,
  input  wire [15:0]          counter_low_wdata,
  input  wire [15:0]          counter_high_wdata,
  input  wire                 fifo_pop,
  output reg  [15:0]          counter_low,
  output reg  [15:0]          counter_high,
  output reg  [31:0]          fifo_data,
  output wire                 fifo_empty,
  output wire                 fifo_overflow,
  output reg                  trigger_status,
  output reg                  compare_out,
  output reg                  sync_out,
  output reg                  primary_irq,
  output reg                  secondary_irq,
  output reg                  compare_irq,
  output reg                  capture_irq,
  output reg                  aux_out
);
  reg  [15:0] tmr_lo_reg;
  reg  [15:0] tmr_hi_reg;
  reg  [31:0] cap_tmr_reg;
  reg  [31:0] cap_view_reg;
  reg  [2:0]  pin_sync_reg;
  reg  [3:0]  edge_cnt_reg;
  reg  [15:0] buf_a_reg;
  reg  [15:0] buf_b_reg;
  reg  [31:0] fifo_mem [0:`FIFO_DEPTH-1];
  reg  [`FIFO_AW:0] wptr_reg;
  reg  [`FIFO_AW:0] rptr_reg;
  reg         ovf_reg;
  reg         cmp_event_reg;
  reg         cap_event_reg;
  reg         roll_reg;
  reg         pin_last_reg;
  reg         cap_fire;

  // single increment shared by both timer halves and the 16-bit capture timer
  function [15:0] inc16;
    input [15:0] v;
    begin
      inc16 = v + 16'h0001;
    end
  endfunction

  // mode decode
  wire        timer_mode = ~capture_select && function_code == `FC_TIMER;  // (R1)
  wire        cap_mode   = capture_select;
  wire        src_sel    = (source_select != `SRC_NONE) && source_in[source_select];  // (R7)
  wire        hold       = ~module_enable | (trigger_enable & ~trigger_status);  // (R10) (R23)
  // dual-edge and center modes are 16-bit only, whatever the wide select
  wire        wide       = wide_timer_select & (function_code != `FC_DUAL_EDGE)
                           & (function_code != `FC_DUAL_BUF) & (function_code != `FC_CENTER);
  wire [31:0] tmr32      = {tmr_hi_reg, tmr_lo_reg};
  wire [31:0] per32      = {period_high, period_low};
  // no source selected gives a plain period rollover
  wire        lo_match   = tmr_lo_reg == period_low;  // (R24)
  wire        hi_match   = tmr_hi_reg == period_high;
  wire        w_match    = tmr32 == per32;
  wire        prim_roll  = wide ? w_match : lo_match;  // (R25)
  wire        sync_clr   = ~trigger_enable & src_sel;  // (R8)
  wire        pin_level  = pin_sync_reg[2];
  // only stages two and three are judged; stage one may still be metastable
  wire        pin_agree  = pin_sync_reg[1] == pin_sync_reg[2];
  wire        pin_rise   = pin_agree & pin_level & ~pin_last_reg;
  wire        pin_fall   = pin_agree & ~pin_level & pin_last_reg;
  // fifo level
  wire [`FIFO_AW:0] fill = wptr_reg - rptr_reg;
  wire        fifo_full  = fill == `FIFO_DEPTH;
  // compare operands
  wire [31:0] cmp_a      = wide ? {compare_a_high, compare_a_low} : {16'h0000, compare_a_low};
  wire [31:0] tmr_cmp    = wide ? tmr32 : {16'h0000, tmr_lo_reg};
  wire        a_hit      = tmr_cmp == cmp_a;
  wire        b_hit      = tmr_lo_reg == buf_b_reg;
  wire        a16_hit    = tmr_lo_reg == buf_a_reg;
  wire        cmp_hit    = a_hit | (b_hit & ~wide);  // (R16)

  assign fifo_empty    = wptr_reg == rptr_reg;
  assign fifo_overflow = ovf_reg;

  always @* begin
    cap_fire = 1'b0;
    case (function_code)
      `IC_EDGE:   cap_fire = pin_rise | pin_fall;  // (R19)
      `IC_RISE:   cap_fire = pin_rise;  // (R19)
      `IC_FALL:   cap_fire = pin_fall;  // (R19)
      `IC_BOTH:   cap_fire = pin_rise | pin_fall;  // (R19)
      `IC_RISE4:  cap_fire = pin_rise && edge_cnt_reg[1:0] == `RISE4_COUNT;  // (R19)
      `IC_RISE16: cap_fire = pin_rise && edge_cnt_reg == `RISE16_COUNT;  // (R19)
      default:    cap_fire = 1'b0;
    endcase
    // inhibit gates the event, not the timer, so the count stays continuous
    cap_fire = cap_fire & cap_mode & module_enable & ~capture_inhibit;
  end

  // pin passes three flops; the edge is judged once stages two and three agree
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync_reg <= 3'h0;
      pin_last_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], capture_pin};
      if (pin_agree)
        pin_last_reg <= pin_level;
    end
  end

  // trigger status: the trigger wins over a clear in the same cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      trigger_status <= 1'b0;
    else if (trigger_enable & module_enable & src_sel)
      trigger_status <= 1'b1;  // (R10)
    // a clear only takes effect once the selected source has dropped
    else if (trigger_clear | ~trigger_enable)
      trigger_status <= 1'b0;  // (R11)
  end

  // general timer and compare time base
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_lo_reg    <= 16'h0000;
      tmr_hi_reg    <= 16'h0000;
      roll_reg      <= 1'b0;
      sync_out      <= 1'b0;
      primary_irq   <= 1'b0;
      secondary_irq <= 1'b0;
    end else begin
      roll_reg      <= 1'b0;
      sync_out      <= 1'b0;
      primary_irq   <= 1'b0;
      secondary_irq <= 1'b0;
      if (counter_write) begin
        tmr_lo_reg <= counter_low_wdata;
        tmr_hi_reg <= counter_high_wdata;
      end else if (cap_mode || hold || sync_clr) begin
        // dual mode sync clears only the primary half; the secondary keeps its count, missing any tick that cycle
        tmr_lo_reg <= 16'h0000;  // (R8) (R11)
        if (wide || cap_mode || hold)
          tmr_hi_reg <= 16'h0000;
      end else if (tick) begin
        if (wide) begin
          if (w_match) begin
            tmr_lo_reg <= 16'h0000;
            tmr_hi_reg <= 16'h0000;
          end else begin
            tmr_lo_reg <= inc16(tmr_lo_reg);
            if (tmr_lo_reg == 16'hFFFF)
              tmr_hi_reg <= inc16(tmr_hi_reg);  // (R5)
          end
        end else begin
          tmr_lo_reg <= lo_match ? 16'h0000 : inc16(tmr_lo_reg);  // (R3)
          tmr_hi_reg <= hi_match ? 16'h0000 : inc16(tmr_hi_reg);  // (R4)
          secondary_irq <= hi_match & timer_mode;  // (R4)
        end
        roll_reg    <= prim_roll;
        sync_out    <= prim_roll;  // (R3) (R25)
        primary_irq <= prim_roll;
      end
    end
  end

  // compare output; buffered modes reload their compare values at rollover
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compare_out   <= 1'b0;
      compare_irq   <= 1'b0;
      cmp_event_reg <= 1'b0;
      buf_a_reg     <= 16'h0000;
      buf_b_reg     <= 16'h0000;
    end else begin
      compare_irq   <= 1'b0;
      cmp_event_reg <= 1'b0;
      if (function_code == `FC_DUAL_EDGE || prim_roll || hold) begin
        buf_a_reg <= compare_a_low;  // (R13) (R14)
        buf_b_reg <= compare_b;
      end
      // buffers track the ports while held, so the first period is not stale
      if (cap_mode || timer_mode || !module_enable) begin
        compare_out <= 1'b0;  // (R1)
      end else if (tick && !hold) begin
        case (function_code)
          `FC_OUT_HIGH:   if (a_hit) compare_out <= 1'b1;  // (R12)
          `FC_OUT_LOW:    if (a_hit) compare_out <= 1'b0;  // (R12)
          `FC_OUT_TOGGLE: if (a_hit) compare_out <= ~compare_out;  // (R12)
          `FC_DUAL_EDGE, `FC_DUAL_BUF: begin
            if (a16_hit) compare_out <= 1'b1;  // (R13)
            else if (b_hit) compare_out <= 1'b0;
          end
          // center pulse: rise on a, fall on b, lying about mid-period
          `FC_CENTER: begin
            if (a16_hit) compare_out <= 1'b1;  // (R14)
            else if (b_hit || lo_match) compare_out <= 1'b0;
          end
          // variable frequency: toggle on a compare match and again at period rollover
          `FC_VARFREQ: if (a_hit || prim_roll) compare_out <= ~compare_out;  // (R15)
          default: compare_out <= compare_out;
        endcase
        cmp_event_reg <= cmp_hit;  // (R16)
        compare_irq   <= cmp_hit;  // (R16)
      end
    end
  end

  // capture timer and fifo
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_tmr_reg   <= 32'h00000000;
      cap_view_reg  <= 32'h00000000;
      edge_cnt_reg  <= 4'h0;
      wptr_reg      <= {(`FIFO_AW+1){1'b0}};
      rptr_reg      <= {(`FIFO_AW+1){1'b0}};
      ovf_reg       <= 1'b0;
      cap_event_reg <= 1'b0;
      capture_irq   <= 1'b0;
      fifo_data     <= 32'h00000000;
    end else begin
      cap_event_reg <= cap_fire;
      capture_irq   <= cap_fire;
      cap_view_reg  <= cap_tmr_reg;  // (R18)
      if (!cap_mode || !module_enable) begin
        cap_tmr_reg  <= 32'h00000000;
        edge_cnt_reg <= 4'h0;
      end else begin
        if (tick)
          cap_tmr_reg <= wide_timer_select ? cap_tmr_reg + 32'h00000001
                         : {16'h0000, inc16(cap_tmr_reg[15:0])};  // (R17)
        if (pin_rise)
          edge_cnt_reg <= edge_cnt_reg + 4'h1;
      end
      // a full fifo keeps its oldest values; the new one is lost, the flag sticks
      if (cap_fire) begin
        if (fifo_full) begin
          ovf_reg <= 1'b1;
        end else begin
          fifo_mem[wptr_reg[`FIFO_AW-1:0]] <= cap_tmr_reg;  // (R17)
          wptr_reg <= wptr_reg + 1'b1;
        end
      end
      if (fifo_pop && !fifo_empty)
        rptr_reg <= rptr_reg + 1'b1;
      // leaving capture mode is the only way to clear the overflow flag
      if (!cap_mode)
        ovf_reg <= 1'b0;
      fifo_data <= fifo_mem[rptr_reg[`FIFO_AW-1:0]];
    end
  end

  // counter outputs show capture timer in capture mode, two cycles late
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counter_low  <= 16'h0000;
      counter_high <= 16'h0000;
    end else begin
      // the extra view stage keeps the readout from tearing between halves
      counter_low  <= cap_mode ? cap_view_reg[15:0] : tmr_lo_reg;  // (R18)
      counter_high <= cap_mode ? cap_view_reg[31:16] : tmr_hi_reg;
    end
  end

  // registered, so other peripherals never see a decode glitch
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      aux_out <= 1'b0;
    else if (auxiliary_select == `AUX_OFF || !module_enable)
      aux_out <= 1'b0;  // (R20)
    else if (cap_mode)
      case (auxiliary_select)
        `AUX_ROLL:  aux_out <= roll_reg;  // (R22)
        `AUX_EVENT: aux_out <= capture_inhibit;  // (R22)
        default:    aux_out <= cap_event_reg;  // (R22)
      endcase
    else if (timer_mode)
      case (auxiliary_select)
        `AUX_ROLL:  aux_out <= roll_reg;  // (R21)
        `AUX_EVENT: aux_out <= roll_reg & trigger_status | roll_reg & ~trigger_enable;  // (R21)
        default:    aux_out <= 1'b0;  // (R21)
      endcase
    else
      case (auxiliary_select)
        `AUX_ROLL:  aux_out <= roll_reg;  // (R22)
        `AUX_EVENT: aux_out <= cmp_event_reg;  // (R22)
        default:    aux_out <= compare_out;  // (R22)
      endcase
  end
endmodule // capture_compare_timer
`default_nettype wire

// file: verilog/capture_compare_timer_consts.vh
/*
 constants for the capture/compare/timer block: mode codes, selects, widths.
 assumes inclusion by bare name from the design file.
*/
`ifndef CAPTURE_COMPARE_TIMER_CONSTS_VH
`define CAPTURE_COMPARE_TIMER_CONSTS_VH
`define FC_TIMER      4'h0
`define FC_OUT_HIGH   4'h1
`define FC_OUT_LOW    4'h2
`define FC_OUT_TOGGLE 4'h3
`define FC_DUAL_EDGE  4'h4
`define FC_DUAL_BUF   4'h5
`define FC_CENTER     4'h6
`define FC_VARFREQ    4'h7
`define IC_EDGE       4'h0
`define IC_RISE       4'h1
`define IC_FALL       4'h2
`define IC_BOTH       4'h3
`define IC_RISE4      4'h4
`define IC_RISE16     4'h5
`define AUX_OFF       2'h0
`define AUX_ROLL      2'h1
`define AUX_EVENT     2'h2
`define AUX_SIGNAL    2'h3
`define SRC_NONE      5'h00
`define FIFO_DEPTH    4
`define FIFO_AW       2
`define RISE4_COUNT   4'h3
`define RISE16_COUNT  4'hF
`endif
